// *** udio_device.sv ***
`timescale 1ns/1ps
module udio_device
  import udio_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  udio_if.dev_mp link,
  input wire logic [31:0] usb_event,
  input wire logic [15:0] dma_event,
  input wire logic suspend_req,
  input wire logic resume_req,
  input wire logic vbus_sense,
  input wire logic core_power_ok,
  input wire logic power_sharing_mode,
  input wire logic dma_req_in,
  output logic clk_run,
  output logic srp_enable,
  output logic int_reset
);
  logic [7:0] mode_reg;
  logic [7:0] icfg_reg;
  logic [31:0] usb_stat_reg;
  logic [31:0] usb_en_reg;
  logic [15:0] dma_stat_reg;
  logic [15:0] dma_en_reg;
  logic [31:0] rdata_reg;
  logic rdata_oe_reg;
  logic rvalid_reg;
  logic irq_active_reg;
  logic irq_active_next;
  logic irq_pin_reg;
  logic irq_pin_next;
  logic [PULSE_CNT_W-1:0] pulse_cnt_reg;
  logic [PULSE_CNT_W-1:0] pulse_cnt_next;
  logic [POR_CNT_W-1:0] por_cnt_reg;
  logic int_reset_reg;
  logic clk_run_reg;
  logic vbus_prev_reg;
  logic suspend_pin_reg;
  logic dma_req_reg;
  logic dma_req_oe_reg;
  logic srp_en_reg;
  logic power_prev_reg;
  logic pending;
  logic asserted;
  logic [31:0] wmask;
  logic [31:0] usb_clr;
  logic [15:0] dma_clr;

  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  // per pipe: icfg field bit 0 lets ack events through, bit 1 nak events
  function automatic logic [31:0] pipe_gate(input logic [7:0] cfg);
    logic [31:0] g;
    g = 32'hFFFFFFFF;
    g[CTRL_EV_LSB +: 2] = cfg[ICFG_CTRL_LSB +: 2];
    g[IN_EV_LSB +: 2] = cfg[ICFG_IN_LSB +: 2];
    g[OUT_EV_LSB +: 2] = cfg[ICFG_OUT_LSB +: 2];
    return g;
  endfunction

  function automatic logic wr_hit(input logic w, input logic [7:0] a,
                                  input logic [7:0] ofs);
    return w && (a == ofs);
  endfunction

  assign wmask = be_mask(link.be) & link.wdata;
  assign usb_clr = wr_hit(link.wr, link.addr, USB_STAT_OFS) ?
                   wmask : 32'h00000000;
  assign dma_clr = wr_hit(link.wr, link.addr, DMA_STAT_OFS) ?
                   wmask[15:0] : 16'h0000;

  // power-on reset pulse, restarted on core power return
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_reg <= POR_CNT_W'(POR_CYCLES);
      power_prev_reg <= 1'b1;
      int_reset_reg <= 1'b1;
    end else begin
      power_prev_reg <= core_power_ok;
      if (core_power_ok && !power_prev_reg) begin
        por_cnt_reg <= POR_CNT_W'(POR_CYCLES);
      end else if (por_cnt_reg != '0) begin
        por_cnt_reg <= por_cnt_reg - 1'b1;
      end
      int_reset_reg <= (por_cnt_reg > POR_CNT_W'(1)) || !power_prev_reg ||
                       !link.reset_pin_n || !core_power_ok;
    end
  end

  // configuration and enable registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MODE_RESET;
      icfg_reg <= ICFG_RESET;
      usb_en_reg <= USB_EN_RESET;
      dma_en_reg <= DMA_EN_RESET;
    end else if (int_reset_reg) begin
      mode_reg <= MODE_RESET;
      icfg_reg <= ICFG_RESET;
      usb_en_reg <= USB_EN_RESET;
      dma_en_reg <= DMA_EN_RESET;
    end else begin
      if (wr_hit(link.wr, link.addr, MODE_OFS)) begin
        mode_reg <= link.be[0] ? link.wdata[7:0] : mode_reg;
      end
      if (wr_hit(link.wr, link.addr, ICFG_OFS)) begin
        icfg_reg <= link.be[0] ? link.wdata[7:0] : icfg_reg;
      end
      if (wr_hit(link.wr, link.addr, USB_EN_OFS)) begin
        usb_en_reg <= (usb_en_reg & ~be_mask(link.be)) | wmask;
      end
      if (wr_hit(link.wr, link.addr, DMA_EN_OFS)) begin
        dma_en_reg <= (dma_en_reg & ~{{8{link.be[1]}}, {8{link.be[0]}}}) |
                      wmask[15:0];
      end
    end
  end

  // status: write one to clear by byte lane, a new event wins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      usb_stat_reg <= 32'h00000000;
      dma_stat_reg <= 16'h0000;
    end else if (int_reset_reg) begin
      usb_stat_reg <= 32'h00000000;
      dma_stat_reg <= 16'h0000;
    end else begin
      usb_stat_reg <= (usb_stat_reg & ~usb_clr) | usb_event;
      dma_stat_reg <= (dma_stat_reg & ~dma_clr) | dma_event;
    end
  end

  // register reads answer one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h00000000;
      rvalid_reg <= 1'b0;
      rdata_oe_reg <= 1'b0;
    end else begin
      rvalid_reg <= link.rd && !int_reset_reg;
      rdata_oe_reg <= link.rd && !int_reset_reg && core_power_ok;
      if (link.rd) begin
        unique case (link.addr)
          MODE_OFS: rdata_reg <= {24'h000000, mode_reg};
          ICFG_OFS: rdata_reg <= {24'h000000, icfg_reg};
          USB_EN_OFS: rdata_reg <= usb_en_reg;
          USB_STAT_OFS: rdata_reg <= usb_stat_reg;
          DMA_STAT_OFS: rdata_reg <= {16'h0000, dma_stat_reg};
          DMA_EN_OFS: rdata_reg <= {16'h0000, dma_en_reg};
          default: rdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // interrupt pin generation
  always_comb begin
    pending = |(usb_stat_reg & usb_en_reg & pipe_gate(icfg_reg)) ||
              |(dma_stat_reg & dma_en_reg);
    if (!pending) begin
      irq_active_next = 1'b0;
    end else if (mode_reg[MODE_GLEN_BIT]) begin
      irq_active_next = 1'b1;
    end else begin
      irq_active_next = irq_active_reg;
    end
    if (irq_active_next && !irq_active_reg) begin
      pulse_cnt_next = PULSE_CNT_W'(IRQ_PULSE_CYCLES);
    end else if (pulse_cnt_reg != '0) begin
      pulse_cnt_next = pulse_cnt_reg - 1'b1;
    end else begin
      pulse_cnt_next = '0;
    end
    if (icfg_reg[ICFG_STYLE_BIT]) begin
      asserted = pulse_cnt_next != '0;
    end else begin
      asserted = irq_active_next;
    end
    if (!core_power_ok) begin
      irq_pin_next = 1'b0;
    end else begin
      irq_pin_next = icfg_reg[ICFG_POL_BIT] ? asserted : !asserted;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_active_reg <= 1'b0;
      pulse_cnt_reg <= '0;
      irq_pin_reg <= 1'b1;
    end else if (int_reset_reg) begin
      irq_active_reg <= 1'b0;
      pulse_cnt_reg <= '0;
      irq_pin_reg <= core_power_ok;
    end else begin
      irq_active_reg <= irq_active_next;
      pulse_cnt_reg <= pulse_cnt_next;
      irq_pin_reg <= irq_pin_next;
    end
  end

  // suspend clock control and bus power wake-up
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_run_reg <= 1'b1;
      vbus_prev_reg <= 1'b0;
    end else begin
      vbus_prev_reg <= vbus_sense;
      if (int_reset_reg) begin
        clk_run_reg <= 1'b1;
      end else if (!clk_run_reg) begin
        clk_run_reg <= (vbus_sense && !vbus_prev_reg) || resume_req;
      end else if (suspend_req && !mode_reg[MODE_CLOCK_ALWAYS_ON_BIT]) begin
        clk_run_reg <= 1'b0;
      end
    end
  end

  // pin states in sharing mode and session request gating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      suspend_pin_reg <= 1'b0;
      dma_req_reg <= 1'b0;
      dma_req_oe_reg <= 1'b0;
      srp_en_reg <= 1'b0;
    end else begin
      suspend_pin_reg <= !core_power_ok || !clk_run_reg;
      dma_req_reg <= dma_req_in && !int_reset_reg;
      dma_req_oe_reg <= core_power_ok && !int_reset_reg;
      srp_en_reg <= !power_sharing_mode && !int_reset_reg;
    end
  end

  assign link.rdata = rdata_reg;
  assign link.rdata_oe = rdata_oe_reg;
  assign link.rvalid = rvalid_reg;
  assign link.irq_pin = irq_pin_reg;
  assign link.suspend_pin = suspend_pin_reg;
  assign link.dma_request_pin = dma_req_reg;
  assign link.dma_request_pin_oe = dma_req_oe_reg;
  assign clk_run = clk_run_reg;
  assign srp_enable = srp_en_reg;
  assign int_reset = int_reset_reg;
endmodule

// *** udio_pkg.sv ***
package udio_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [7:0] MODE_OFS = 8'h0C;
  localparam logic [7:0] ICFG_OFS = 8'h10;
  localparam logic [7:0] USB_EN_OFS = 8'h14;
  localparam logic [7:0] USB_STAT_OFS = 8'h18;
  localparam logic [7:0] DMA_STAT_OFS = 8'h50;
  localparam logic [7:0] DMA_EN_OFS = 8'h54;
  localparam int MODE_GLEN_BIT = 3;
  localparam int MODE_CLOCK_ALWAYS_ON_BIT = 7;
  localparam int ICFG_STYLE_BIT = 0;
  localparam int ICFG_POL_BIT = 1;
  localparam int ICFG_CTRL_LSB = 2;
  localparam int ICFG_IN_LSB = 4;
  localparam int ICFG_OUT_LSB = 6;
  localparam int CTRL_EV_LSB = 8;
  localparam int IN_EV_LSB = 10;
  localparam int OUT_EV_LSB = 12;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] ICFG_RESET = 8'h54;
  localparam logic [31:0] USB_EN_RESET = 32'h00000000;
  localparam logic [15:0] DMA_EN_RESET = 16'h0000;
  localparam int IRQ_PULSE_NS = 60;
  localparam int IRQ_PULSE_CYCLES =
    (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_PULSE_NS = 200;
  localparam int POR_CYCLES = (POR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_MIN_US = 500;
  localparam int RESET_MIN_CYCLES = RESET_MIN_US * 1000 / CLK_PERIOD_NS;
  localparam int RESET_SHARE_MS = 2;
  localparam int RESET_SHARE_CYCLES = RESET_SHARE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int POR_CNT_W = 5;
  localparam int PULSE_CNT_W = 3;
  localparam int RST_CNT_W = 18;
  localparam logic [7:0] HCMD_OFS = 8'h00;
  localparam logic [7:0] HADDR_OFS = 8'h04;
  localparam logic [7:0] HWDATA_OFS = 8'h08;
  localparam logic [7:0] HRDATA_OFS = 8'h0C;
  localparam logic [7:0] HSTAT_OFS = 8'h10;
  localparam logic [7:0] HCFG_OFS = 8'h14;
  localparam int CMD_WR_BIT = 0;
  localparam int CMD_RD_BIT = 1;
  localparam int CMD_RST_BIT = 2;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_IRQ_BIT = 1;
  localparam int STAT_RDONE_BIT = 2;
  localparam int STAT_VBUS_BIT = 3;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_WRITE = 3'b001,
    HS_READ = 3'b010,
    HS_WAIT = 3'b011,
    HS_RESET = 3'b100
  } udio_host_state_type;
endpackage

// *** udio_if.sv ***
`timescale 1ns/1ps
interface udio_if;
  logic reset_pin_n;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic rdata_oe;
  logic rvalid;
  logic irq_pin;
  logic suspend_pin;
  logic dma_request_pin;
  logic dma_request_pin_oe;
  modport dev_mp (
    input reset_pin_n,
    input addr,
    input wdata,
    input be,
    input wr,
    input rd,
    output rdata,
    output rdata_oe,
    output rvalid,
    output irq_pin,
    output suspend_pin,
    output dma_request_pin,
    output dma_request_pin_oe
  );
  modport host_mp (
    output reset_pin_n,
    output addr,
    output wdata,
    output be,
    output wr,
    output rd,
    input rdata,
    input rdata_oe,
    input rvalid,
    input irq_pin,
    input suspend_pin,
    input dma_request_pin,
    input dma_request_pin_oe
  );
endinterface

// *** udio_host.sv ***
`timescale 1ns/1ps
module udio_host
  import udio_pkg::*;
#(
  parameter int RESET_PULSE_CYCLES = RESET_SHARE_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  udio_if.host_mp link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic vbus_sensed,
  output logic irq_qualified
);
  udio_host_state_type state_reg;
  logic [7:0] addr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] rdbuf_reg;
  logic rdone_reg;
  logic pol_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic wr_reg;
  logic rd_reg;
  logic rpin_reg;
  logic irq_q_reg;
  logic [RST_CNT_W-1:0] rst_cnt_reg;
  logic apb_wr;
  logic cmd_wr;
  logic [31:0] stat_word;

  assign apb_wr = psel && penable && pready_reg && pwrite;
  assign cmd_wr = apb_wr && (paddr == HCMD_OFS) && (state_reg == HS_IDLE);
  always_comb begin
    stat_word = 32'h00000000;
    stat_word[STAT_BUSY_BIT] = state_reg != HS_IDLE;
    stat_word[STAT_IRQ_BIT] = irq_q_reg;
    stat_word[STAT_RDONE_BIT] = rdone_reg;
    stat_word[STAT_VBUS_BIT] = vbus_sensed;
  end

  // apb slave: one wait-free access phase, read data loaded at setup
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      pready_reg <= psel && !penable;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          HADDR_OFS: prdata_reg <= {24'h000000, addr_reg};
          HWDATA_OFS: prdata_reg <= wdata_reg;
          HRDATA_OFS: prdata_reg <= rdbuf_reg;
          HSTAT_OFS: prdata_reg <= stat_word;
          HCFG_OFS: prdata_reg <= {31'h00000000, pol_reg};
          default: prdata_reg <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= 8'h00;
      wdata_reg <= 32'h00000000;
      pol_reg <= 1'b0;
    end else if (apb_wr) begin
      if (paddr == HADDR_OFS) begin
        addr_reg <= pwdata[7:0];
      end
      if (paddr == HWDATA_OFS) begin
        wdata_reg <= pwdata;
      end
      if (paddr == HCFG_OFS) begin
        pol_reg <= pwdata[0];
      end
    end
  end

  // device access sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= HS_IDLE;
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      rpin_reg <= 1'b1;
      rst_cnt_reg <= '0;
      rdbuf_reg <= 32'h00000000;
      rdone_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        HS_IDLE: begin
          if (cmd_wr && pwdata[CMD_RST_BIT]) begin
            rpin_reg <= 1'b0;
            rst_cnt_reg <= RST_CNT_W'(RESET_PULSE_CYCLES);
            state_reg <= HS_RESET;
          end else if (cmd_wr && pwdata[CMD_RD_BIT]) begin
            rd_reg <= 1'b1;
            rdone_reg <= 1'b0;
            state_reg <= HS_READ;
          end else if (cmd_wr && pwdata[CMD_WR_BIT]) begin
            wr_reg <= 1'b1;
            state_reg <= HS_WRITE;
          end
        end
        HS_WRITE: begin
          wr_reg <= 1'b0;
          state_reg <= HS_IDLE;
        end
        HS_READ: begin
          rd_reg <= 1'b0;
          state_reg <= HS_WAIT;
        end
        HS_WAIT: begin
          if (link.rvalid) begin
            rdbuf_reg <= link.rdata;
            rdone_reg <= 1'b1;
            state_reg <= HS_IDLE;
          end
        end
        HS_RESET: begin
          if (rst_cnt_reg <= RST_CNT_W'(1)) begin
            rpin_reg <= 1'b1;
            state_reg <= HS_IDLE;
          end else begin
            rst_cnt_reg <= rst_cnt_reg - 1'b1;
          end
        end
        default: state_reg <= HS_IDLE;
      endcase
    end
  end

  // interrupt taken only while bus power is sensed
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q_reg <= 1'b0;
    end else begin
      irq_q_reg <= vbus_sensed && (link.irq_pin == pol_reg);
    end
  end

  assign link.reset_pin_n = rpin_reg;
  assign link.addr = addr_reg;
  assign link.wdata = wdata_reg;
  assign link.be = 4'hF;
  assign link.wr = wr_reg;
  assign link.rd = rd_reg;
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = 1'b0;
  assign irq_qualified = irq_q_reg;
endmodule

// *** udio_assertions.sv ***
`timescale 1ns/1ps
module udio_assertions
  import udio_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] be,
  input wire logic wr,
  input wire logic rd,
  input wire logic rdata_oe,
  input wire logic rvalid,
  input wire logic irq_pin,
  input wire logic suspend_pin
);
  logic glen_reg;
  logic [7:0] icfg_reg;
  logic act;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // shadows of enable and config, snooped from link writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      glen_reg <= MODE_RESET[MODE_GLEN_BIT];
    end else if (!reset_pin_n) begin
      glen_reg <= MODE_RESET[MODE_GLEN_BIT];
    end else if (wr && be[0] && addr == MODE_OFS) begin
      glen_reg <= wdata[MODE_GLEN_BIT];
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      icfg_reg <= ICFG_RESET;
    end else if (!reset_pin_n) begin
      icfg_reg <= ICFG_RESET;
    end else if (wr && be[0] && addr == ICFG_OFS) begin
      icfg_reg <= wdata[7:0];
    end
  end
  assign act = (irq_pin == icfg_reg[ICFG_POL_BIT]);
  property p_rst_idle;
    !reset_pin_n [*3] |-> irq_pin && !suspend_pin;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("pin not idle");
  property p_pulse;
    icfg_reg[ICFG_STYLE_BIT] && $rose(act) && $stable(icfg_reg)
      |-> act [*6] ##1 !act;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width");
  property p_mask;
    !glen_reg && !act && $stable(icfg_reg) |=> !act;
  endproperty
  a_mask: assert property (p_mask) else $error("masked pin");
  property p_keep;
    !icfg_reg[ICFG_STYLE_BIT] && act && reset_pin_n && $fell(glen_reg)
      |=> act;
  endproperty
  a_keep: assert property (p_keep) else $error("pin dropped");
  property p_hold;
    !icfg_reg[ICFG_STYLE_BIT] && act && !wr && !$past(wr) && !suspend_pin
      && reset_pin_n && $past(reset_pin_n) && $stable(icfg_reg) |=> act;
  endproperty
  a_hold: assert property (p_hold) else $error("level lost");
  property p_read;
    rvalid |-> rdata_oe && $past(rd);
  endproperty
  a_read: assert property (p_read) else $error("read answer");
  property p_bytes;
    wr |-> be == 4'hF;
  endproperty
  a_bytes: assert property (p_bytes) else $error("partial write");
  property p_wr_once;
    wr |=> !wr;
  endproperty
  a_wr_once: assert property (p_wr_once) else $error("double write");
  c_pulse: cover property (icfg_reg[ICFG_STYLE_BIT] && $rose(act));
  c_keep: cover property ($fell(glen_reg) && act);
  c_read: cover property (rvalid);
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top
  import udio_pkg::*;
;
  localparam int RPC = 100;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] usb_event = 32'h0;
  logic [15:0] dma_event = 16'h0;
  logic suspend_req = 1'b0;
  logic vbus_sense = 1'b0;
  logic core_power_ok = 1'b1;
  logic power_sharing_mode = 1'b0;
  logic dma_req_in = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic clk_run;
  logic srp_enable;
  logic int_reset;
  logic [31:0] prdata;
  logic pready;
  logic irq_qualified;
  logic [31:0] rv;
  int n_errors = 0;
  int checks_done = 0;
  always #5 core_clk = ~core_clk;
  udio_if link_if();
  udio_device udio_device_i(.core_clk(core_clk), .rst_n(rst_n),
    .link(link_if), .usb_event(usb_event), .dma_event(dma_event),
    .suspend_req(suspend_req), .resume_req(1'b0), .vbus_sense(vbus_sense),
    .core_power_ok(core_power_ok), .power_sharing_mode(power_sharing_mode),
    .dma_req_in(dma_req_in), .clk_run(clk_run), .srp_enable(srp_enable),
    .int_reset(int_reset));
  udio_host #(.RESET_PULSE_CYCLES(RPC)) udio_host_i(.core_clk(core_clk),
    .rst_n(rst_n), .link(link_if), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .vbus_sensed(vbus_sense),
    .irq_qualified(irq_qualified));
  udio_assertions udio_assertions_i(.core_clk(core_clk), .rst_n(rst_n),
    .reset_pin_n(link_if.reset_pin_n), .addr(link_if.addr),
    .wdata(link_if.wdata), .be(link_if.be), .wr(link_if.wr),
    .rd(link_if.rd), .rdata_oe(link_if.rdata_oe), .rvalid(link_if.rvalid),
    .irq_pin(link_if.irq_pin), .suspend_pin(link_if.suspend_pin));
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic pin(input logic e);
    chk("irq_pin", {31'h0, e}, {31'h0, link_if.irq_pin});
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 50) begin
      chk("pready", 32'h1, 32'h0);
      close_out();
    end
  endtask
  task automatic dw(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, HADDR_OFS, {24'h0, a}, rv);
    apb(1'b1, HWDATA_OFS, d, rv);
    apb(1'b1, HCMD_OFS, 32'h1, rv);
    tick(5);
  endtask
  task automatic dr(input logic [7:0] a, output logic [31:0] q);
    int i;
    apb(1'b1, HADDR_OFS, {24'h0, a}, q);
    apb(1'b1, HCMD_OFS, 32'h2, q);
    for (i = 0; i < 20; i++) begin
      apb(1'b0, HSTAT_OFS, 32'h0, q);
      if (q[STAT_RDONE_BIT] === 1'b1) break;
    end
    if (i == 20) begin
      chk("rdone", 32'h1, 32'h0);
      close_out();
    end
    apb(1'b0, HRDATA_OFS, 32'h0, q);
  endtask
  task automatic ev(input logic [31:0] u, input logic [15:0] dm);
    @(posedge core_clk);
    usb_event <= u;
    dma_event <= dm;
    @(posedge core_clk);
    usb_event <= 32'h0;
    dma_event <= 16'h0;
    tick(4);
  endtask
  task automatic s_mask();
    dr(ICFG_OFS, rv);
    chk("icfg", {24'h0, ICFG_RESET}, rv);
    pin(1'b1);
    dw(USB_EN_OFS, 32'h1);
    dw(DMA_EN_OFS, 32'h1);
    ev(32'h1, 16'h0);
    pin(1'b1);
    dr(USB_STAT_OFS, rv);
    chk("usb_stat", 32'h1, rv);
    dw(MODE_OFS, 32'h8);
    pin(1'b0);
    chk("irq_q_novbus", 32'h0, {31'h0, irq_qualified});
    tick(10);
    pin(1'b0);
    dw(MODE_OFS, 32'h0);
    pin(1'b0);
    dw(USB_STAT_OFS, 32'hFFFFFFFF);
    pin(1'b1);
    dw(MODE_OFS, 32'h8);
    ev(32'h2, 16'h0);
    pin(1'b1);
    ev(32'h0, 16'h1);
    pin(1'b0);
    dw(DMA_STAT_OFS, 32'hFFFFFFFF);
    pin(1'b1);
    dw(USB_STAT_OFS, 32'hFFFFFFFF);
  endtask
  task automatic s_pulse();
    int i;
    int n;
    dw(ICFG_OFS, 32'h57);
    pin(1'b0);
    n = 0;
    @(posedge core_clk);
    usb_event <= 32'h1;
    @(posedge core_clk);
    usb_event <= 32'h0;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (link_if.irq_pin === 1'b1) n++;
    end
    chk("pulse_len", IRQ_PULSE_CYCLES, n);
    dw(USB_STAT_OFS, 32'hFFFFFFFF);
    dw(ICFG_OFS, 32'h54);
  endtask
  task automatic s_pipe();
    int p;
    dw(USB_EN_OFS, 32'h3F00);
    for (p = 0; p < 3; p++) begin
      dw(ICFG_OFS, 32'h0);
      ev(32'h100 << (2 * p), 16'h0);
      pin(1'b1);
      dw(ICFG_OFS, 32'h4 << (2 * p));
      pin(1'b0);
      dw(USB_STAT_OFS, 32'hFFFFFFFF);
      pin(1'b1);
      ev(32'h200 << (2 * p), 16'h0);
      pin(1'b1);
      dw(ICFG_OFS, 32'h8 << (2 * p));
      pin(1'b0);
      dw(USB_STAT_OFS, 32'hFFFFFFFF);
      pin(1'b1);
    end
  endtask
  task automatic s_host_reset();
    int i;
    int n;
    apb(1'b1, HCMD_OFS, 32'h4, rv);
    n = 0;
    for (i = 0; i < 300; i++) begin
      @(posedge core_clk);
      if (link_if.reset_pin_n === 1'b0) n++;
    end
    chk("reset_width", RPC, n);
    dr(ICFG_OFS, rv);
    chk("icfg_rst", {24'h0, ICFG_RESET}, rv);
  endtask
  task automatic s_clock();
    dw(MODE_OFS, 32'h8);
    suspend_req <= 1'b1;
    tick(5);
    chk("clk_off", 32'h0, {31'h0, clk_run});
    suspend_req <= 1'b0;
    vbus_sense <= 1'b1;
    tick(5);
    chk("clk_on", 32'h1, {31'h0, clk_run});
    dw(USB_EN_OFS, 32'h1);
    ev(32'h1, 16'h0);
    pin(1'b0);
    chk("irq_q_vbus", 32'h1, {31'h0, irq_qualified});
  endtask
  task automatic s_share();
    int i;
    int n;
    dma_req_in <= 1'b1;
    tick(2);
    chk("dma_pin", 32'h3, {30'h0, link_if.dma_request_pin,
      link_if.dma_request_pin_oe});
    power_sharing_mode <= 1'b1;
    core_power_ok <= 1'b0;
    vbus_sense <= 1'b0;
    tick(4);
    chk("share_pins", 32'h4, {28'h0, link_if.irq_pin, link_if.suspend_pin,
      link_if.rdata_oe, link_if.dma_request_pin_oe});
    chk("irq_q_share", 32'h0, {31'h0, irq_qualified});
    core_power_ok <= 1'b1;
    n = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk);
      if (int_reset === 1'b1) n++;
    end
    chk("por_len", 32'h1,
      {31'h0, n >= POR_CYCLES && n <= POR_CYCLES + 3});
    chk("srp", 32'h0, {31'h0, srp_enable});
  endtask
  initial begin
    tick(4);
    rst_n <= 1'b1;
    tick(30);
    s_mask();
    s_pulse();
    s_pipe();
    s_host_reset();
    s_clock();
    s_share();
    close_out();
  end
endmodule
